// ===== design/sdcmd_pkg.sv
// Constants and command codes for the SDRAM command front end.
// Assumes a 100 MHz system clock that also clocks the command pins.
// How it works
// - Write auto precharge starts one clock plus 7.5ns
// - Chip select high decodes as no operation
// - Data outputs high impedance after precharge
// - Column ignores A11/A12 by organisation width
// - Clock-count spacings stay fixed cycle counts
package sdcmd_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W = 13;
    localparam int BA_W = 2;
    localparam int NBANK = 4;
    localparam int COL_W = 12;
    localparam int BCNT_W = 10;

    // ****************************************
    // Mode register fields and reset value
    // ****************************************
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_CL_LSB = 4;
    localparam int AP_BIT = 10;
    localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;
    localparam logic [2:0] BL_FULL_PAGE = 3'h7;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 10000;
    localparam int WR_AP_TIME_PS = 7500;
    // Least time, so round up, never below one cycle
    localparam int WR_AP_CYC_RAW = (WR_AP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_AP_CYC = (WR_AP_CYC_RAW < 1) ? 1 : WR_AP_CYC_RAW;
    localparam int LMR_SPACING_CLK = 2;

    // ****************************************
    // Commands
    // ****************************************
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_ACT,
        CMD_RD,
        CMD_WR,
        CMD_PRE,
        CMD_REF,
        CMD_LMR,
        CMD_BST
    } sdcmd_cmd_type;

endpackage

// ===== design/sdcmd_decode.sv
// Command and column decoder for the SDRAM command pins.
// Assumes pins are already sampled on the system clock; purely combinational.
`timescale 1ns/1ns
module sdcmd_decode #(
    parameter int ORG_WIDTH = 16
) (
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [sdcmd_pkg::ADDR_W-1:0] addr_i,
    output sdcmd_pkg::sdcmd_cmd_type cmd_o,
    output logic [sdcmd_pkg::COL_W-1:0] col_o
);

    // ****************************************
    // Command truth table
    // ****************************************
    // chip select gating
    always_comb begin
        cmd_o = sdcmd_pkg::CMD_NOP;
        if (!cs_n_i) begin
            unique case ({ras_n_i, cas_n_i, we_n_i})
                3'h3: cmd_o = sdcmd_pkg::CMD_ACT;
                3'h5: cmd_o = sdcmd_pkg::CMD_RD;
                3'h4: cmd_o = sdcmd_pkg::CMD_WR;
                3'h2: cmd_o = sdcmd_pkg::CMD_PRE;
                3'h1: cmd_o = sdcmd_pkg::CMD_REF;
                3'h0: cmd_o = sdcmd_pkg::CMD_LMR;
                3'h6: cmd_o = sdcmd_pkg::CMD_BST;
                3'h7: cmd_o = sdcmd_pkg::CMD_NOP;
            endcase
        end
    end

    // ****************************************
    // Column address
    // ****************************************
    // drop unused high bits
    // A10 carries auto precharge, so it is never part of the column
    always_comb begin
        col_o = {addr_i[12], addr_i[11], addr_i[9:0]};
        if (ORG_WIDTH == 16) begin
            col_o[11:10] = 2'h0;
        end else if (ORG_WIDTH == 8) begin
            col_o[11] = 1'h0;
        end
    end

endmodule

// ===== design/sdcmd_core.sv
// Command front end of a four-bank SDRAM: decode, bank state, write
// auto precharge timing and read output enable.
// Assumes command pins are synchronous to clk_sys_i and CKE low freezes commands.
`timescale 1ns/1ns
module sdcmd_core #(
    parameter int ORG_WIDTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [sdcmd_pkg::BA_W-1:0] ba_i,
    input wire logic [sdcmd_pkg::ADDR_W-1:0] addr_i,
    output sdcmd_pkg::sdcmd_cmd_type cmd_o,
    output logic [sdcmd_pkg::COL_W-1:0] col_o,
    output logic [sdcmd_pkg::NBANK-1:0] bank_open_o,
    output logic [sdcmd_pkg::ADDR_W-1:0] mode_o,
    output logic wr_en_o,
    output logic dq_oe_o,
    output logic pre_start_o,
    output logic [sdcmd_pkg::BA_W-1:0] pre_bank_o,
    output logic spacing_err_o
);

    // ****************************************
    // Elaboration check
    // ****************************************
    if (ORG_WIDTH != 4 && ORG_WIDTH != 8 && ORG_WIDTH != 16) begin : g_bad_org
        $error("ORG_WIDTH must be 4, 8 or 16");
    end

    typedef enum logic [1:0] {WR_IDLE, WR_BURST, WR_RECOV} sdcmd_wr_type;

    // ****************************************
    // Decode
    // ****************************************
    sdcmd_pkg::sdcmd_cmd_type dec_cmd;
    sdcmd_pkg::sdcmd_cmd_type cmd_eff;
    logic [sdcmd_pkg::COL_W-1:0] dec_col;

    sdcmd_decode #(
        .ORG_WIDTH(ORG_WIDTH)
    ) u_decode (
        .cs_n_i(cs_n_i),
        .ras_n_i(ras_n_i),
        .cas_n_i(cas_n_i),
        .we_n_i(we_n_i),
        .addr_i(addr_i),
        .cmd_o(dec_cmd),
        .col_o(dec_col)
    );

    // Clock suspend: with CKE low the edge carries no command
    assign cmd_eff = cke_i ? dec_cmd : sdcmd_pkg::CMD_NOP;

    // Burst length from mode field; full page counts to the 10-bit counter limit
    function automatic logic [sdcmd_pkg::BCNT_W-1:0] burst_len(input logic [2:0] code);
        logic [sdcmd_pkg::BCNT_W-1:0] len;
        len = 10'h001;
        unique case (code)
            3'h0: len = 10'h001;
            3'h1: len = 10'h002;
            3'h2: len = 10'h004;
            3'h3: len = 10'h008;
            default: len = 10'h3FF;
        endcase
        return len;
    endfunction

    // ****************************************
    // State
    // ****************************************
    sdcmd_wr_type wr_state_q, wr_state_d;
    logic [sdcmd_pkg::BCNT_W-1:0] wr_left_q, wr_left_d;
    logic wr_ap_q, wr_ap_d;
    logic [sdcmd_pkg::BA_W-1:0] wr_bank_q, wr_bank_d;
    logic [1:0] ap_cnt_q, ap_cnt_d;
    logic [2:0] rd_lat_q, rd_lat_d;
    logic [sdcmd_pkg::BCNT_W-1:0] rd_left_q, rd_left_d;
    logic rd_ap_q, rd_ap_d;
    logic [sdcmd_pkg::BA_W-1:0] rd_bank_q, rd_bank_d;
    logic [1:0] lmr_cnt_q, lmr_cnt_d;
    sdcmd_pkg::sdcmd_cmd_type cmd_q;
    logic [sdcmd_pkg::COL_W-1:0] col_q;
    logic [sdcmd_pkg::NBANK-1:0] bank_open_q, bank_open_d;
    logic [sdcmd_pkg::ADDR_W-1:0] mode_q, mode_d;
    logic wr_en_q, wr_en_d;
    logic dq_oe_q, dq_oe_d;
    logic pre_start_q, pre_start_d;
    logic [sdcmd_pkg::BA_W-1:0] pre_bank_q, pre_bank_d;
    logic spacing_err_q, spacing_err_d;
    logic [sdcmd_pkg::BCNT_W-1:0] bl_now;

    assign bl_now = burst_len(mode_q[sdcmd_pkg::MODE_BL_LSB +: 3]);

    // ****************************************
    // Next state
    // ****************************************
    // One pass covers writes, reads, banks and spacing, since a command
    // on one edge may end a burst and open or close a bank together
    always_comb begin
        wr_state_d = wr_state_q;
        wr_left_d = wr_left_q;
        wr_ap_d = wr_ap_q;
        wr_bank_d = wr_bank_q;
        ap_cnt_d = ap_cnt_q;
        rd_lat_d = rd_lat_q;
        rd_left_d = rd_left_q;
        rd_ap_d = rd_ap_q;
        rd_bank_d = rd_bank_q;
        lmr_cnt_d = (lmr_cnt_q != 2'h0) ? lmr_cnt_q - 2'h1 : 2'h0;
        bank_open_d = bank_open_q;
        mode_d = mode_q;
        wr_en_d = 1'b0;
        dq_oe_d = 1'b0;
        pre_start_d = 1'b0;
        pre_bank_d = pre_bank_q;
        spacing_err_d = 1'b0;

        // Write burst progress; data sampled with the command itself
        unique case (wr_state_q)
            WR_IDLE: begin
            end
            WR_BURST: begin
                wr_en_d = 1'b1;
                wr_left_d = wr_left_q - 10'h001;
                if (wr_left_q == 10'h001) begin
                    wr_state_d = wr_ap_q ? WR_RECOV : WR_IDLE;
                    ap_cnt_d = 2'(sdcmd_pkg::WR_AP_CYC);
                end
            end
            WR_RECOV: begin
                ap_cnt_d = ap_cnt_q - 2'h1;
                if (ap_cnt_q == 2'h1) begin
                    pre_start_d = 1'b1;
                    pre_bank_d = wr_bank_q;
                    bank_open_d[wr_bank_q] = 1'b0;
                    wr_state_d = WR_IDLE;
                end
            end
        endcase

        // Read output window after CAS latency
        if (rd_lat_q != 3'h0) begin
            rd_lat_d = rd_lat_q - 3'h1;
        end else if (rd_left_q != 10'h000) begin
            dq_oe_d = 1'b1;
            rd_left_d = rd_left_q - 10'h001;
            if (rd_left_q == 10'h001 && rd_ap_q) begin
                bank_open_d[rd_bank_q] = 1'b0;
            end
        end

        unique case (cmd_eff)
            sdcmd_pkg::CMD_NOP, sdcmd_pkg::CMD_REF: begin
            end
            sdcmd_pkg::CMD_ACT: begin
                bank_open_d[ba_i] = 1'b1;
            end
            sdcmd_pkg::CMD_WR: begin
                wr_en_d = 1'b1;
                wr_ap_d = addr_i[sdcmd_pkg::AP_BIT];
                wr_bank_d = ba_i;
                wr_left_d = bl_now - 10'h001;
                ap_cnt_d = 2'(sdcmd_pkg::WR_AP_CYC);
                if (bl_now != 10'h001) begin
                    wr_state_d = WR_BURST;
                end else begin
                    wr_state_d = addr_i[sdcmd_pkg::AP_BIT] ? WR_RECOV : WR_IDLE;
                end
                rd_lat_d = 3'h0;
                rd_left_d = 10'h000;
            end
            sdcmd_pkg::CMD_RD: begin
                rd_lat_d = mode_q[sdcmd_pkg::MODE_CL_LSB +: 3] - 3'h1;
                rd_left_d = bl_now;
                rd_ap_d = addr_i[sdcmd_pkg::AP_BIT];
                rd_bank_d = ba_i;
                wr_state_d = WR_IDLE;
            end
            sdcmd_pkg::CMD_BST: begin
                wr_state_d = WR_IDLE;
                rd_lat_d = 3'h0;
                rd_left_d = 10'h000;
            end
            sdcmd_pkg::CMD_PRE: begin
                rd_lat_d = 3'h0;
                rd_left_d = 10'h000;
                dq_oe_d = 1'b0;
                if (addr_i[sdcmd_pkg::AP_BIT]) begin
                    bank_open_d = '0;
                end else begin
                    bank_open_d[ba_i] = 1'b0;
                end
            end
            sdcmd_pkg::CMD_LMR: begin
                mode_d = addr_i;
                lmr_cnt_d = 2'(sdcmd_pkg::LMR_SPACING_CLK - 1);
            end
        endcase

        if ((cmd_eff == sdcmd_pkg::CMD_ACT || cmd_eff == sdcmd_pkg::CMD_REF)
            && lmr_cnt_q != 2'h0) begin
            spacing_err_d = 1'b1;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Synchronous reset puts every bank closed and outputs quiet
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wr_state_q <= WR_IDLE;
            wr_left_q <= '0;
            wr_ap_q <= 1'b0;
            wr_bank_q <= '0;
            ap_cnt_q <= 2'h0;
            rd_lat_q <= 3'h0;
            rd_left_q <= '0;
            rd_ap_q <= 1'b0;
            rd_bank_q <= '0;
            lmr_cnt_q <= 2'h0;
            cmd_q <= sdcmd_pkg::CMD_NOP;
            col_q <= '0;
            bank_open_q <= '0;
            mode_q <= sdcmd_pkg::MODE_RESET;
            wr_en_q <= 1'b0;
            dq_oe_q <= 1'b0;
            pre_start_q <= 1'b0;
            pre_bank_q <= '0;
            spacing_err_q <= 1'b0;
        end else begin
            wr_state_q <= wr_state_d;
            wr_left_q <= wr_left_d;
            wr_ap_q <= wr_ap_d;
            wr_bank_q <= wr_bank_d;
            ap_cnt_q <= ap_cnt_d;
            rd_lat_q <= rd_lat_d;
            rd_left_q <= rd_left_d;
            rd_ap_q <= rd_ap_d;
            rd_bank_q <= rd_bank_d;
            lmr_cnt_q <= lmr_cnt_d;
            cmd_q <= cmd_eff;
            col_q <= dec_col;
            bank_open_q <= bank_open_d;
            mode_q <= mode_d;
            wr_en_q <= wr_en_d;
            dq_oe_q <= dq_oe_d;
            pre_start_q <= pre_start_d;
            pre_bank_q <= pre_bank_d;
            spacing_err_q <= spacing_err_d;
        end
    end

    assign cmd_o = cmd_q;
    assign col_o = col_q;
    assign bank_open_o = bank_open_q;
    assign mode_o = mode_q;
    assign wr_en_o = wr_en_q;
    assign dq_oe_o = dq_oe_q;
    assign pre_start_o = pre_start_q;
    assign pre_bank_o = pre_bank_q;
    assign spacing_err_o = spacing_err_q;

    // ****************************************
    // Assertions
    // ****************************************
    AST_CS_NOP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cs_n_i |=> (cmd_o == sdcmd_pkg::CMD_NOP))
        else $error("command decoded with chip select high");

    AST_AP_SINGLE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (cmd_eff == sdcmd_pkg::CMD_WR && bl_now == 10'h001 && addr_i[sdcmd_pkg::AP_BIT])
        ##1 (cmd_eff == sdcmd_pkg::CMD_NOP) |=> pre_start_o && (pre_bank_o == $past(ba_i, 2)))
        else $error("auto precharge start not one clock plus delay after last data");

    AST_AP_ONLY_RECOV: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(pre_start_o) |-> $past(wr_state_q == WR_RECOV) && !bank_open_o[pre_bank_o])
        else $error("precharge start without write recovery");

    AST_PRE_HIZ: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (cmd_eff == sdcmd_pkg::CMD_PRE) ##1 (cmd_eff != sdcmd_pkg::CMD_RD)[*2] |-> !dq_oe_o)
        else $error("outputs driven after precharge");

    AST_COL_MASK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $past(resetn_i) |-> (col_o[9:0] == $past(addr_i[9:0]))
            && (ORG_WIDTH != 16 || col_o[11:10] == 2'h0))
        else $error("ignored column bits reached the column");

    AST_LMR_SPACE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (cmd_eff == sdcmd_pkg::CMD_LMR) ##1 (cmd_eff == sdcmd_pkg::CMD_ACT) |=> spacing_err_o)
        else $error("active one clock after mode load not flagged");

endmodule

// ===== bench/sdcmd_ctrl_model.sv
// Behavioural memory controller that drives the SDRAM command pins.
// Assumes the bench calls its tasks just after a rising edge, reset released.
`timescale 1ns/1ns
module sdcmd_ctrl_model #(
    parameter int INIT_CYC = 20,
    parameter int WR_REC_CYC = 2,
    // Self refresh exit wait, slower grade rounded up to whole cycles
    parameter int XSR_CYC = 8
) (
    input wire logic clk_sys_i,
    output logic cke_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [sdcmd_pkg::BA_W-1:0] ba_o,
    output logic [sdcmd_pkg::ADDR_W-1:0] addr_o
);
    // ****************************************
    // Pin drivers
    // ****************************************
    // Pin codes {ras,cas,we} by command, NOP in the low slot
    localparam logic [23:0] CODES = {3'h6, 3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3, 3'h7};
    int cyc_count;

    // Deselected and idle from time zero
    initial begin
        {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = 5'h1F;
        ba_o = 2'h0;
        addr_o = 13'h0000;
        cyc_count = 0;
    end

    // Pins held across exactly one rising edge; the task returns 1 ns after it with the pins still driven
    task automatic drive(input logic cke, input logic cs_n, input logic [2:0] rcw,
                         input logic [1:0] ba, input logic [12:0] addr);
        {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = {cke, cs_n, rcw};
        ba_o = ba;
        addr_o = addr;
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic issue(input sdcmd_pkg::sdcmd_cmd_type c, input logic [1:0] ba,
                         input logic [12:0] addr);
        drive(1'b1, 1'b0, CODES[3*int'(c) +: 3], ba, addr);
    endtask

    task automatic idle(input int n);
        repeat (n) drive(1'b1, 1'b1, 3'h7, 2'h0, 13'h0000);
    endtask

    task automatic refresh_pair();
        issue(sdcmd_pkg::CMD_REF, 2'h0, 13'h0000);
        idle(6);
        issue(sdcmd_pkg::CMD_REF, 2'h0, 13'h0000);
        idle(6);
    endtask

    task automatic precharge(input logic [1:0] ba);
        idle(WR_REC_CYC);
        issue(sdcmd_pkg::CMD_PRE, ba, 13'h0000);
    endtask

    // clock keeps running through the exit wait
    task automatic self_refresh(input int n);
        drive(1'b0, 1'b0, 3'h1, 2'h0, 13'h0000);
        repeat (n) drive(1'b0, 1'b1, 3'h7, 2'h0, 13'h0000);
        idle(XSR_CYC);
    endtask

    task automatic init(input logic [12:0] mode);
        cyc_count = 0;
        while (cyc_count < INIT_CYC) begin
            idle(1);
            cyc_count++;
        end
        issue(sdcmd_pkg::CMD_PRE, 2'h0, 13'h0400);
        idle(1);
        issue(sdcmd_pkg::CMD_LMR, 2'h0, mode);
        idle(2);
        refresh_pair();
    endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the SDRAM command front end.
// Assumes the controller model drives every command pin.
`timescale 1ns/1ns
module testbench;
    // ****************************************
    // Signals and instances
    // ****************************************
    typedef struct {logic [4:0] pins; sdcmd_pkg::sdcmd_cmd_type exp;} sdcmd_row_type;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0] ba, pre_bank;
    logic [12:0] addr, mode;
    sdcmd_pkg::sdcmd_cmd_type cmd;
    logic [11:0] col;
    logic [3:0] bank_open;
    logic wr_en, dq_oe, pre_start, spacing_err;
    int bad_count = 0;
    int compares = 0;
    // Pins are {cke, cs_n, ras_n, cas_n, we_n}
    sdcmd_row_type rows [11] = '{
        '{5'h03, sdcmd_pkg::CMD_NOP}, '{5'h18, sdcmd_pkg::CMD_NOP},
        '{5'h1B, sdcmd_pkg::CMD_NOP}, '{5'h17, sdcmd_pkg::CMD_NOP},
        '{5'h13, sdcmd_pkg::CMD_ACT}, '{5'h15, sdcmd_pkg::CMD_RD},
        '{5'h16, sdcmd_pkg::CMD_BST}, '{5'h14, sdcmd_pkg::CMD_WR},
        '{5'h12, sdcmd_pkg::CMD_PRE}, '{5'h11, sdcmd_pkg::CMD_REF},
        '{5'h10, sdcmd_pkg::CMD_LMR}};

    always #5 clk_sys_i = ~clk_sys_i;

    sdcmd_ctrl_model ctrl (.clk_sys_i(clk_sys_i), .cke_o(cke), .cs_n_o(cs_n),
        .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr));

    sdcmd_core #(.ORG_WIDTH(16)) DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
        .ba_i(ba), .addr_i(addr), .cmd_o(cmd), .col_o(col), .bank_open_o(bank_open),
        .mode_o(mode), .wr_en_o(wr_en), .dq_oe_o(dq_oe), .pre_start_o(pre_start),
        .pre_bank_o(pre_bank), .spacing_err_o(spacing_err));

    // ****************************************
    // Compare and report
    // ****************************************
    task automatic chk_vec(input logic [12:0] got, input logic [12:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_vec({12'h000, got}, {12'h000, exp});
    endtask

    task automatic chk_cmd(input sdcmd_pkg::sdcmd_cmd_type got,
                           input sdcmd_pkg::sdcmd_cmd_type exp);
        chk_vec({10'h000, got}, {10'h000, exp});
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard: running out counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        bad_count++;
        complete_run();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk_sys_i);
        #1;
        chk_cmd(cmd, sdcmd_pkg::CMD_NOP); // reset state
        chk_vec({5'h00, bank_open, wr_en, dq_oe, pre_start, spacing_err}, 13'h0000);
        resetn_i = 1'b1;
        ctrl.init(13'h0022);
        chk_vec(mode, 13'h0022); // mode kept
        chk_bit(dq_oe, 1'b0); // outputs off
        // Decode table, BL4 CL2 in force
        foreach (rows[i]) begin
            ctrl.drive(rows[i].pins[4], rows[i].pins[3], rows[i].pins[2:0], 2'h1, 13'h0022);
            chk_cmd(cmd, rows[i].exp); // decoded command per row
        end
        ctrl.idle(2);
        // Single write with auto precharge, BL1
        ctrl.issue(sdcmd_pkg::CMD_LMR, 2'h0, 13'h0020);
        ctrl.idle(2);
        ctrl.issue(sdcmd_pkg::CMD_ACT, 2'h2, 13'h0100);
        ctrl.idle(2);
        chk_bit(bank_open[2], 1'b1); // bank open
        ctrl.issue(sdcmd_pkg::CMD_WR, 2'h2, 13'h0400);
        chk_bit(wr_en, 1'b1); // beat taken
        chk_bit(pre_start, 1'b0); // not yet
        ctrl.idle(1);
        chk_bit(pre_start, 1'b1); // period starts
        chk_vec({11'h000, pre_bank}, 13'h0002); // right bank
        chk_bit(bank_open[2], 1'b0); // bank closed
        // Single read with auto precharge, BL1 CL2, no second read early
        ctrl.idle(2);
        ctrl.issue(sdcmd_pkg::CMD_ACT, 2'h2, 13'h0A88);
        ctrl.idle(2);
        ctrl.issue(sdcmd_pkg::CMD_RD, 2'h2, 13'h0407);
        ctrl.idle(2); // hold off a second read
        chk_bit(dq_oe, 1'b1); // single beat out
        chk_bit(bank_open[2], 1'b0); // auto precharge closed
        ctrl.idle(1);
        chk_bit(dq_oe, 1'b0); // one beat only
        // Read BL4 CL2 cut by precharge; high column bits dropped for x16
        ctrl.issue(sdcmd_pkg::CMD_LMR, 2'h0, 13'h0022);
        ctrl.idle(2);
        ctrl.issue(sdcmd_pkg::CMD_ACT, 2'h1, 13'h0000);
        ctrl.idle(2);
        ctrl.issue(sdcmd_pkg::CMD_RD, 2'h1, 13'h1855);
        chk_vec({1'h0, col}, 13'h0055); // column mask
        chk_bit(dq_oe, 1'b0); // latency gap
        ctrl.idle(2);
        chk_bit(dq_oe, 1'b1); // data driven
        ctrl.issue(sdcmd_pkg::CMD_PRE, 2'h1, 13'h0000);
        chk_bit(dq_oe, 1'b0); // off after precharge
        chk_bit(bank_open[1], 1'b0); // bank closed
        // Write without auto precharge, explicit precharge after recovery
        ctrl.issue(sdcmd_pkg::CMD_ACT, 2'h3, 13'h0A88);
        ctrl.idle(2);
        ctrl.issue(sdcmd_pkg::CMD_WR, 2'h3, 13'h1308);
        chk_bit(bank_open[3], 1'b1); // still open
        ctrl.idle(3); // remaining beats of the burst
        chk_bit(wr_en, 1'b1); // last beat taken
        ctrl.precharge(2'h3);
        chk_bit(bank_open[3], 1'b0); // closed
        // Mode load spacing for both ACT and REF
        for (int k = 0; k < 2; k++) begin
            ctrl.issue(sdcmd_pkg::CMD_LMR, 2'h0, 13'h0022);
            ctrl.issue(k ? sdcmd_pkg::CMD_REF : sdcmd_pkg::CMD_ACT, 2'h0, 13'h0000);
            chk_bit(spacing_err, 1'b1); // too close
            ctrl.idle(1);
            chk_bit(spacing_err, 1'b0); // single pulse
            ctrl.precharge(2'h0);
            ctrl.issue(sdcmd_pkg::CMD_LMR, 2'h0, 13'h0022);
            ctrl.idle(1);
            ctrl.issue(k ? sdcmd_pkg::CMD_REF : sdcmd_pkg::CMD_ACT, 2'h0, 13'h0000);
            chk_bit(spacing_err, 1'b0); // two clocks fine
            ctrl.precharge(2'h0);
        end
        // Power-down: commands with cke low are ignored, then refresh again
        repeat (3) ctrl.drive(1'b0, 1'b0, 3'h3, 2'h0, 13'h0000);
        chk_bit(bank_open[0], 1'b0); // no activate
        // Self refresh entry with cke low, exit wait, then activate
        ctrl.self_refresh(4); // exit wait
        chk_bit(bank_open[0], 1'b0); // nothing opened meanwhile
        ctrl.issue(sdcmd_pkg::CMD_ACT, 2'h0, 13'h0000);
        chk_bit(bank_open[0], 1'b1); // activate taken
        ctrl.precharge(2'h0);
        ctrl.refresh_pair();
        // Reset in mid-run with a bank open
        ctrl.issue(sdcmd_pkg::CMD_ACT, 2'h0, 13'h0000);
        resetn_i = 1'b0;
        ctrl.idle(2);
        chk_vec({9'h000, bank_open}, 13'h0000); // reset clears banks
        chk_vec(mode, 13'h0000); // reset clears mode
        chk_cmd(cmd, sdcmd_pkg::CMD_NOP); // reset state
        resetn_i = 1'b1;
        // First command on the first edge after reset is taken
        ctrl.issue(sdcmd_pkg::CMD_ACT, 2'h1, 13'h0000);
        chk_vec({9'h000, bank_open}, 13'h0002); // first edge after reset
        ctrl.idle(2);
        complete_run();
    end
endmodule
